// *** src/dual_panel_video_dma.sv ***
`timescale 1ns/1ps
`default_nettype none
module dual_panel_video_dma
    import dual_panel_video_dma_pkg::*;
#(
    parameter int QW_W = 128
)(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic      [31:0]       prdata,
    input  wire logic              frame_start,
    input  wire logic              vid_req,
    input  wire logic [RASTER_W-1:0] raster_line,
    output logic                   mem_req,
    output fetch_t                 mem_fetch,
    input  wire logic              mem_ack,
    input  wire logic [QW_W-1:0]   mem_rdata,
    output logic                   vid_valid,
    output logic                   vid_lower,
    output logic      [QW_W-1:0]   vid_data,
    output logic                   cursor_upper_on,
    output logic                   cursor_lower_on
);

    typedef enum logic [1:0] {ST_IDLE, ST_UPPER, ST_LOWER} state_t;

    state_t      state_r;
    logic [7:0]  ctrl_r;
    logic [31:0] fb_base_r, fb_last_r, up_init_r, lo_init_r, up_ptr_r, lo_ptr_r;
    logic [15:0] cur_vstart_r, cur_vend_r, disp_vstart_r, disp_vend_r;
    logic        pend_r;
    logic        wr_en, rd_en, addr_ok, duplex, enable;
    cur_mode_t   cur_mode;

    // Step a panel pointer, wrapping from the last quadword to the base
    function automatic logic [31:0] next_ptr(input logic [31:0] p, input logic [31:0] last,
                                             input logic [31:0] base);
        if ((p & QW_ALIGN) == (last & QW_ALIGN))
            next_ptr = base & QW_ALIGN;
        else
            next_ptr = (p & QW_ALIGN) + QW_STEP;
    endfunction

    // Inclusive raster window test
    function automatic logic in_win(input logic [RASTER_W-1:0] l, input logic [RASTER_W-1:0] a,
                                    input logic [RASTER_W-1:0] b);
        in_win = (l >= a) && (l <= b);
    endfunction

    assign duplex   = ctrl_r[CTRL_DUPLEX_BIT]; // [RULE_09]
    assign enable   = ctrl_r[CTRL_ENABLE_BIT];
    assign cur_mode = cur_mode_t'(cur_vstart_r[CUR_MODE_LSB+1:CUR_MODE_LSB]); // [RULE_04]

    // APB slave: zero wait states, unmapped addresses answer with pslverr
    assign pready = 1'b1;
    assign wr_en  = psel && penable && pwrite;
    assign rd_en  = psel && penable && !pwrite;

    always_comb
    begin
        addr_ok = 1'b1;
        prdata  = 32'h0000_0000;
        if (paddr == OFF_DMA_CTRL)
            prdata = {24'h00_0000, ctrl_r};
        else if (paddr == OFF_FB_BASE)
            prdata = fb_base_r;
        else if (paddr == OFF_FB_LAST)
            prdata = fb_last_r;
        else if (paddr == OFF_UP_INIT)
            prdata = up_init_r;
        else if (paddr == OFF_LO_INIT)
            prdata = lo_init_r;
        else if (paddr == OFF_CUR_VSTART)
            prdata = {16'h0000, cur_vstart_r};
        else if (paddr == OFF_CUR_VEND)
            prdata = {16'h0000, cur_vend_r};
        else if (paddr == OFF_DISP_VERT)
            prdata = {disp_vend_r, disp_vstart_r};
        else if (paddr == OFF_STATUS)
            prdata = {29'h0000_0000, pend_r, state_r == ST_LOWER, state_r != ST_IDLE};
        else if (paddr == OFF_UP_PTR)
            prdata = up_ptr_r;
        else if (paddr == OFF_LO_PTR)
            prdata = lo_ptr_r;
        else
            addr_ok = 1'b0;
    end
    assign pslverr = psel && penable && !addr_ok;

    // Software-written configuration
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r        <= DMA_CTRL_RST;
            fb_base_r     <= PTR_RST;
            fb_last_r     <= PTR_RST;
            up_init_r     <= PTR_RST;
            lo_init_r     <= PTR_RST;
            cur_vstart_r  <= VREG_RST;
            cur_vend_r    <= VREG_RST;
            disp_vstart_r <= VREG_RST;
            disp_vend_r   <= VREG_RST;
        end
        else if (wr_en)
        begin
            if (paddr == OFF_DMA_CTRL)
                ctrl_r <= pwdata[7:0];
            else if (paddr == OFF_FB_BASE)
                fb_base_r <= pwdata;
            else if (paddr == OFF_FB_LAST)
                fb_last_r <= pwdata;
            else if (paddr == OFF_UP_INIT)
                up_init_r <= pwdata;
            else if (paddr == OFF_LO_INIT)
                lo_init_r <= pwdata;
            else if (paddr == OFF_CUR_VSTART)
                cur_vstart_r <= pwdata[15:0];
            else if (paddr == OFF_CUR_VEND)
                cur_vend_r <= pwdata[15:0];
            else if (paddr == OFF_DISP_VERT)
            begin
                disp_vstart_r <= pwdata[15:0];
                disp_vend_r   <= pwdata[31:16];
            end
        end
    end

    // One request is remembered while a fetch runs; a new one beats the idle clear, but frame start or disable clears it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pend_r <= 1'b0;
        else if (!enable || frame_start)
            pend_r <= 1'b0;
        else if (vid_req)
            pend_r <= 1'b1;
        else if (state_r == ST_IDLE)
            pend_r <= 1'b0;
    end

    // Fetch sequencer: upper quadword first, then the lower one in duplex
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_r <= ST_IDLE;
        else if (!enable)
            state_r <= ST_IDLE;
        else
        begin
            case (state_r)
                ST_IDLE:
                    if (pend_r && !frame_start)
                        state_r <= ST_UPPER; // [RULE_03]
                ST_UPPER:
                    if (mem_ack)
                        state_r <= duplex ? ST_LOWER : ST_IDLE; // [RULE_08]
                ST_LOWER:
                    if (mem_ack)
                        state_r <= ST_IDLE;
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    // Panel pointers: reload per frame, step a quadword, wrap independently
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            up_ptr_r <= PTR_RST;
            lo_ptr_r <= PTR_RST;
        end
        else if (frame_start)
        begin
            up_ptr_r <= up_init_r & QW_ALIGN; // [RULE_21] [RULE_17] [RULE_14]
            lo_ptr_r <= lo_init_r & QW_ALIGN; // [RULE_10]
        end
        else if (mem_ack && state_r == ST_UPPER)
            up_ptr_r <= next_ptr(up_ptr_r, fb_last_r, fb_base_r); // [RULE_11] [RULE_21]
        else if (mem_ack && state_r == ST_LOWER)
            lo_ptr_r <= next_ptr(lo_ptr_r, fb_last_r, fb_base_r); // [RULE_11] [RULE_21]
    end

    // Request stands from entry of a fetch state until its acknowledge
    assign mem_req         = (state_r == ST_UPPER) || (state_r == ST_LOWER);
    // One driver for the whole struct; the half tag also picks the pointer
    assign mem_fetch = {(state_r == ST_LOWER) ? lo_ptr_r : up_ptr_r,
                        state_r == ST_LOWER}; // [RULE_03]

    // Fetched quadword goes to the macrocell, tagged with its half
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            vid_valid <= 1'b0;
            vid_lower <= 1'b0;
            vid_data  <= '0;
        end
        else
        begin
            vid_valid <= mem_req && mem_ack;
            if (mem_req && mem_ack)
            begin
                vid_lower <= mem_fetch.lower; // [RULE_03]
                vid_data  <= mem_rdata;
            end
        end
    end

    // Cursor windows; the spanning case swaps the meaning of start and end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cursor_upper_on <= 1'b0;
            cursor_lower_on <= 1'b0;
        end
        else
        begin
            case (cur_mode)
                CUR_SINGLE, CUR_UPPER:
                begin
                    cursor_upper_on <= in_win(raster_line, cur_vstart_r[RASTER_W-1:0],
                                              cur_vend_r[RASTER_W-1:0]); // [RULE_05]
                    cursor_lower_on <= 1'b0;
                end
                CUR_LOWER:
                begin
                    cursor_upper_on <= 1'b0;
                    cursor_lower_on <= in_win(raster_line, cur_vstart_r[RASTER_W-1:0],
                                              cur_vend_r[RASTER_W-1:0]); // [RULE_05]
                end
                default:
                begin
                    cursor_lower_on <= in_win(raster_line, disp_vstart_r[RASTER_W-1:0],
                                              cur_vstart_r[RASTER_W-1:0]); // [RULE_06] [RULE_07]
                    cursor_upper_on <= in_win(raster_line, cur_vend_r[RASTER_W-1:0],
                                              disp_vend_r[RASTER_W-1:0]); // [RULE_06] [RULE_07]
                end
            endcase
        end
    end

    // Checks
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    pair_follows_a: assert property (state_r == ST_UPPER && mem_ack && duplex && enable
        |=> mem_req && mem_fetch.lower) else $error("lower fetch did not follow"); // [RULE_08]
    upper_first_a: assert property ($rose(mem_req) |-> !mem_fetch.lower)
        else $error("pair did not start upper"); // [RULE_03]
    step_qw_a: assert property (state_r == ST_UPPER && mem_ack && !frame_start
        && (up_ptr_r & QW_ALIGN) != (fb_last_r & QW_ALIGN)
        |=> up_ptr_r == ($past(up_ptr_r) & QW_ALIGN) + QW_STEP)
        else $error("upper pointer step wrong"); // [RULE_11]
    wrap_base_a: assert property (state_r == ST_LOWER && mem_ack && !frame_start
        && (lo_ptr_r & QW_ALIGN) == (fb_last_r & QW_ALIGN)
        |=> lo_ptr_r == ($past(fb_base_r) & QW_ALIGN))
        else $error("lower pointer did not wrap"); // [RULE_21]
    frame_reload_a: assert property (frame_start
        |=> up_ptr_r == ($past(up_init_r) & QW_ALIGN)
        && lo_ptr_r == ($past(lo_init_r) & QW_ALIGN))
        else $error("pointers not reloaded"); // [RULE_10]
    req_hold_a: assert property (mem_req && !mem_ack && enable |=> mem_req && $stable(mem_fetch))
        else $error("fetch request dropped"); // [RULE_03]
    span_lower_a: assert property (cur_mode == CUR_SPAN && $stable(cur_mode)
        && raster_line >= disp_vstart_r[RASTER_W-1:0]
        && raster_line <= cur_vstart_r[RASTER_W-1:0] && $stable(cur_vstart_r)
        && $stable(disp_vstart_r) |=> cursor_lower_on)
        else $error("spanning lower cursor missing"); // [RULE_07]
    single_lower_off_a: assert property (cur_mode == CUR_UPPER |=> !cursor_lower_on)
        else $error("upper-only cursor shown low"); // [RULE_04]
    data_tag_a: assert property (mem_req && mem_ack |=> vid_valid
        && vid_lower == $past(mem_fetch.lower)) else $error("data tag wrong"); // [RULE_03]

    pair_done_c: cover property (state_r == ST_LOWER && mem_ack);
    wrap_c: cover property (state_r == ST_UPPER && mem_ack
        && (up_ptr_r & QW_ALIGN) == (fb_last_r & QW_ALIGN));
    span_c: cover property (cur_mode == CUR_SPAN && cursor_lower_on);

endmodule
`default_nettype wire

// *** src/dual_panel_video_dma_pkg.sv ***
// Function
// (RULE_01) Software sets the LCD bit in the extended video control word.
// (RULE_02) Software sets the two-panel bit in the video macrocell control word.
// (RULE_03) First quadword of a pair feeds the upper half, second the lower half.
// (RULE_04) Cursor vertical start bits 14:13 pick off, upper, lower or spanning cursor; code 00 (CUR_SINGLE) shows the cursor in the upper half as 01 does.
// (RULE_05) Cursor in one half: start and end are raster counts as on one panel.
// (RULE_06) Spanning cursor: start counts to cursor end in lower, end to start in upper.
// (RULE_07) Spanning: lower shows display start to cursor start, upper cursor end to display end.
// (RULE_08) In two-panel mode every video request is served as a back-to-back pair.
// (RULE_09) Software enables two-panel sequencing through bit 7 of the video DMA control.
// (RULE_10) The two quadwords of a pair lie half the video buffer apart.
// (RULE_11) Each video pointer advances by 0x10 bytes after every fetch.
// (RULE_12) Software loads buffer base and last address as for a single panel.
// (RULE_13) Software points the two initial pointers half a buffer apart.
// (RULE_14) Upper initial pointer may lie in the lower half of the buffer.
// (RULE_15) Software sets bit 30 of an initial pointer equal to the last address.
// (RULE_16) Software never sets both final-quadword flags together.
// (RULE_17) Pointers are quadword aligned; low address bits are ignored.
// (RULE_18) Software keeps four cursor images so each row starts on a quadword.
// (RULE_19) Spanning cursor pointer is set to the row at the top of the lower half.
// (RULE_20) Frame buffer holds an even number of quadwords; buffers quadword aligned.
// (RULE_21) Each panel pointer wraps last to base and reloads at every frame start.
package dual_panel_video_dma_pkg;

    // Register byte offsets
    localparam logic [11:0] OFF_DMA_CTRL   = 12'h1e0;
    localparam logic [11:0] OFF_FB_BASE    = 12'h1e4;
    localparam logic [11:0] OFF_FB_LAST    = 12'h1e8;
    localparam logic [11:0] OFF_UP_INIT    = 12'h1ec;
    localparam logic [11:0] OFF_LO_INIT    = 12'h1f0;
    localparam logic [11:0] OFF_CUR_VSTART = 12'h1f4;
    localparam logic [11:0] OFF_CUR_VEND   = 12'h1f8;
    localparam logic [11:0] OFF_DISP_VERT  = 12'h1fc;
    localparam logic [11:0] OFF_STATUS     = 12'h200;
    localparam logic [11:0] OFF_UP_PTR     = 12'h204;
    localparam logic [11:0] OFF_LO_PTR     = 12'h208;

    // Field positions
    localparam int CTRL_DUPLEX_BIT = 7;
    localparam int CTRL_ENABLE_BIT = 4;
    localparam int PTR_LAST_BIT    = 30;
    localparam int CUR_MODE_LSB    = 13;
    localparam int RASTER_W        = 13;
    localparam int DISP_END_LSB    = 16;

    // Reset values
    localparam logic [7:0]  DMA_CTRL_RST = 8'h00;
    localparam logic [31:0] PTR_RST      = 32'h0000_0000;
    localparam logic [15:0] VREG_RST     = 16'h0000;

    // Quadword step and alignment mask
    localparam logic [31:0] QW_STEP  = 32'h0000_0010;
    localparam logic [31:0] QW_ALIGN = 32'h3fff_fff0;

    // Cursor placement codes
    typedef enum logic [1:0] {
        CUR_SINGLE = 2'b00,
        CUR_UPPER  = 2'b01,
        CUR_LOWER  = 2'b10,
        CUR_SPAN   = 2'b11
    } cur_mode_t;

    // One memory fetch request
    typedef struct packed {
        logic [31:0] addr;
        logic        lower;
    } fetch_t;

endpackage

// *** bench/mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module mem_model
    import dual_panel_video_dma_pkg::*;
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [1:0]   lat,
    input  wire logic         mem_req,
    input  wire fetch_t       mem_fetch,
    output logic              mem_ack,
    output logic      [127:0] mem_rdata
);
    logic [1:0] cnt_r;

    // Answers after lat extra cycles, data is the fetch address repeated
    // Between answers the data flips every cycle, so stale data never matches
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r     <= 2'h0;
            mem_ack   <= 1'b0;
            mem_rdata <= 128'h0;
        end
        else
        begin
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata;
            // Skip the ack edge itself so one request is never answered twice
            if (mem_req && !mem_ack)
            begin
                if (cnt_r >= lat)
                begin
                    mem_ack   <= 1'b1;
                    mem_rdata <= {4{mem_fetch.addr}};
                    cnt_r     <= 2'h0;
                end
                else
                begin
                    cnt_r <= cnt_r + 2'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench
    import dual_panel_video_dma_pkg::*;
;
    localparam logic [31:0] FB_BASE = 32'h0000_1000;
    localparam logic [31:0] FB_LAST = 32'h0000_10f0;
    localparam int RAST[7] = '{5, 10, 20, 30, 40, 100, 101};

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic frame_start, vid_req, mem_req, mem_ack, vid_valid, vid_lower;
    logic cursor_upper_on, cursor_lower_on;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [RASTER_W-1:0] raster_line;
    logic [1:0] lat;
    logic [127:0] mem_rdata, vid_data;
    fetch_t mem_fetch;
    int error_cnt, n_compared;

    dual_panel_video_dma u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .pslverr(pslverr), .prdata(prdata), .frame_start(frame_start),
        .vid_req(vid_req), .raster_line(raster_line), .mem_req(mem_req),
        .mem_fetch(mem_fetch), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .vid_valid(vid_valid), .vid_lower(vid_lower), .vid_data(vid_data),
        .cursor_upper_on(cursor_upper_on), .cursor_lower_on(cursor_lower_on));

    mem_model u_mem (.pclk(pclk), .presetn(presetn), .lat(lat), .mem_req(mem_req),
        .mem_fetch(mem_fetch), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    task automatic check(input logic [127:0] seen, input logic [127:0] exp, input string what);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("compares %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // One APB transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20)
        begin
            error_cnt++;
            final_report;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    // Bounded wait for one video quadword
    task automatic wait_vid(output logic [127:0] d, output logic low);
        int i;
        for (i = 0; i < 20; i++)
        begin
            @(posedge pclk); #1;
            if (vid_valid === 1'b1) break;
        end
        if (i == 20)
        begin
            error_cnt++;
            final_report;
        end
        d = vid_data;
        low = vid_lower;
    endtask

    task automatic reg_test;
        apb(1'b0, OFF_DMA_CTRL, 32'h0);
        check(rd, {24'h0, DMA_CTRL_RST}, "ctrl reset value");
        apb(1'b1, OFF_DMA_CTRL, 32'h0000_0090);
        apb(1'b0, OFF_DMA_CTRL, 32'h0);
        check(rd, 32'h0000_0090, "ctrl readback");
        apb(1'b1, OFF_UP_INIT, FB_LAST | 32'h4000_0000);
        apb(1'b0, OFF_UP_INIT, 32'h0);
        check(rd, FB_LAST | 32'h4000_0000, "last flag kept");
        apb(1'b1, 12'h300, 32'hffff_ffff);
        check(err, 1'b1, "unmapped error");
        check(rd, 32'h0, "unmapped data");
        $display("register test done");
    endtask

    // Frame start, then pairs; expected pointers step and wrap independently
    task automatic run_frame(input logic [31:0] up0, input logic [31:0] lo0, input int pairs,
                             input logic [1:0] l);
        logic [31:0] up, lo;
        logic [127:0] d;
        logic low;
        up = up0;
        lo = lo0;
        @(posedge pclk);
        frame_start <= 1'b1; lat <= l;
        @(posedge pclk);
        frame_start <= 1'b0;
        for (int k = 0; k < pairs; k++)
        begin
            @(posedge pclk);
            vid_req <= 1'b1; // Macrocell in LCD duplex asks once per pair
            @(posedge pclk);
            vid_req <= 1'b0;
            wait_vid(d, low);
            check(low, 1'b0, "upper half first");
            check(d, {4{up}}, "upper address");
            wait_vid(d, low);
            check(low, 1'b1, "lower half second");
            check(d, {4{lo}}, "lower address");
            up = (up == FB_LAST) ? FB_BASE : up + QW_STEP;
            lo = (lo == FB_LAST) ? FB_BASE : lo + QW_STEP;
        end
        $display("frame test done");
    endtask

    // With the enable bit clear a request must not reach memory
    // With duplex clear a request fetches the upper quadword alone
    task automatic disabled_test;
        logic seen;
        logic [127:0] d;
        logic low;
        seen = 1'b0;
        apb(1'b1, OFF_DMA_CTRL, 32'h0000_0080);
        @(posedge pclk);
        vid_req <= 1'b1;
        @(posedge pclk);
        vid_req <= 1'b0;
        repeat (10)
        begin
            @(posedge pclk); #1;
            if (vid_valid !== 1'b0 || mem_req !== 1'b0) seen = 1'b1;
        end
        check(seen, 1'b0, "disabled fetch");
        apb(1'b1, OFF_DMA_CTRL, 32'h0000_0010);
        @(posedge pclk);
        vid_req <= 1'b1;
        @(posedge pclk);
        vid_req <= 1'b0;
        wait_vid(d, low);
        check(low, 1'b0, "single fetch half");
        check(d, {4{32'h0000_1080 + 2 * QW_STEP}}, "single fetch address");
        repeat (10)
        begin
            @(posedge pclk); #1;
            if (vid_valid !== 1'b0) seen = 1'b1;
        end
        check(seen, 1'b0, "no second quadword");
        $display("disable test done");
    endtask

    // All four cursor codes across window edges; windows are inclusive
    task automatic cursor_scan;
        logic eu, el;
        int r;
        apb(1'b1, OFF_CUR_VEND, 32'd40);
        apb(1'b1, OFF_DISP_VERT, {16'd100, 16'd10});
        // Code 3 models software that set the cursor pointer to the lower top row
        // and keeps aligned cursor images, so only the windows matter
        for (int m = 0; m < 4; m++)
        begin
            apb(1'b1, OFF_CUR_VSTART, (32'(m) << 13) | 32'd20);
            for (int j = 0; j < 7; j++)
            begin
                r = RAST[j];
                @(posedge pclk);
                raster_line <= r[RASTER_W-1:0];
                @(posedge pclk); #1;
                eu = (m == 3) ? (r >= 40 && r <= 100) : (m != 2 && r >= 20 && r <= 40);
                el = (m == 3) ? (r >= 10 && r <= 20) : (m == 2 && r >= 20 && r <= 40);
                check(cursor_upper_on, eu, "cursor upper");
                check(cursor_lower_on, el, "cursor lower");
            end
        end
        $display("cursor test done");
    endtask

    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    initial
    begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0;
        pwdata = 32'h0; frame_start = 1'b0; vid_req = 1'b0; raster_line = '0; lat = 2'h0;
        error_cnt = 0; n_compared = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        reg_test;
        // Sixteen quadwords, aligned, halves 0x80 bytes apart
        apb(1'b1, OFF_FB_BASE, FB_BASE);
        apb(1'b1, OFF_FB_LAST, FB_LAST);
        apb(1'b1, OFF_UP_INIT, 32'h0000_1000);
        apb(1'b1, OFF_LO_INIT, 32'h0000_1080);
        run_frame(32'h0000_1000, 32'h0000_1080, 9, 2'h0);
        run_frame(32'h0000_1000, 32'h0000_1080, 1, 2'h3);
        apb(1'b1, OFF_UP_INIT, 32'h0000_1080);
        apb(1'b1, OFF_LO_INIT, 32'h0000_1000);
        run_frame(32'h0000_1080, 32'h0000_1000, 2, 2'h2);
        disabled_test;
        cursor_scan;
        final_report;
    end
endmodule
`default_nettype wire
